// ### common/tlc_pkg.sv
// shared constants and types for the traverse and fixed-length control block
package tlc_pkg;
    localparam int CLK_NS = 50;
    localparam int TENTH_S_NS = 100_000_000;
    localparam int CYC_PER_TENTH = TENTH_S_NS / CLK_NS;
    localparam int PERMILLE = 1000;
    localparam logic [15:0] M_PER_CM100 = 16'h2710;
    localparam int CFG_NUM = 18;
    // register index; byte address is four times the index
    localparam logic [4:0] IDX_CTRL = 5'h00;
    localparam logic [4:0] IDX_CENTRE = 5'h01;
    localparam logic [4:0] IDX_FMAX = 5'h02;
    localparam logic [4:0] IDX_FUPPER = 5'h03;
    localparam logic [4:0] IDX_FLOWER = 5'h04;
    localparam logic [4:0] IDX_PRESET = 5'h05;
    localparam logic [4:0] IDX_WAIT = 5'h06;
    localparam logic [4:0] IDX_AMP = 5'h07;
    localparam logic [4:0] IDX_JUMP = 5'h08;
    localparam logic [4:0] IDX_RISE = 5'h09;
    localparam logic [4:0] IDX_FALL = 5'h0A;
    localparam logic [4:0] IDX_ACC = 5'h0B;
    localparam logic [4:0] IDX_DEC = 5'h0C;
    localparam logic [4:0] IDX_SETLEN = 5'h0D;
    localparam logic [4:0] IDX_MAG = 5'h0E;
    localparam logic [4:0] IDX_CORR = 5'h0F;
    localparam logic [4:0] IDX_CIRC = 5'h10;
    localparam logic [4:0] IDX_PPR = 5'h11;
    localparam logic [4:0] IDX_ACTLEN = 5'h12;
    localparam logic [4:0] IDX_STATUS = 5'h13;
    // control register bit positions
    localparam int CTL_TRAV_EN = 0;
    localparam int CTL_MANUAL = 1;
    localparam int CTL_VAR_AMP = 2;
    localparam int CTL_RESTART = 3;
    localparam int CTL_NO_STORE = 4;
    localparam int CTL_LEN_EN = 5;
    localparam logic [15:0] CFG_RST [CFG_NUM] = '{
        16'h0000, 16'h0000, 16'h1388, 16'h1388, 16'h0000, 16'h03E8,
        16'h0000, 16'h0000, 16'h0000, 16'h0032, 16'h0032, 16'h0064,
        16'h0064, 16'h0000, 16'h03E8, 16'h03E8, 16'h03E8, 16'h03E8};
    localparam logic [15:0] ACTLEN_RST = 16'h0000;
    // synchronised pin positions
    localparam int PIN_SHAFT = 0;
    localparam int PIN_TRAV = 1;
    localparam int PIN_CLR = 2;
    localparam int PIN_DIR = 3;
    localparam int PIN_PFAIL = 4;
    localparam int PIN_NUM = 5;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PRESET = 3'b001,
        ST_WAIT = 3'b010,
        ST_TRACK = 3'b011,
        ST_RISE = 3'b100,
        ST_FALL = 3'b101,
        ST_STOP = 3'b110
    } tlc_state_t;
endpackage

// ### tb/tlc_shaft_model.sv
// measuring shaft pulse source driving the block's shaft pin
`timescale 1ns/1ps
module tlc_shaft_model (
    input wire logic clk_i,
    output logic shaft_o
);
    initial shaft_o = 1'b0;
    // each level lasts past the pin synchroniser so no edge is lost
    task automatic burst(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (6) @(posedge clk_i);
            shaft_o <= 1'b1;
            repeat (6) @(posedge clk_i);
            shaft_o <= 1'b0;
        end
        repeat (8) @(posedge clk_i);
    endtask
endmodule

// ### tb/tlc_top_bench.sv
// self-checking bench for the traverse and fixed-length block
`timescale 1ns/1ps
module tlc_top_bench;
    import tlc_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rdv;
    logic run_i, run_rev_i, jog_i, pid_i, stage_switch_i, stage_neg_i, shaft;
    logic trav_t, clr_t, dir_ext_i, power_fail_i;
    logic dir_o, stop_o, stage_skip_o, trav_o, nv_save_o;
    logic [15:0] stage_time_i, freq_o, nv_len_o, fmax, fmin, mag, corr, up, prev, jup;
    int errors, samples_checked, seed, n, k;
    tlc_top #(.CYC_TENTH(20)) tlc_top_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .run_i(run_i), .run_rev_i(run_rev_i),
        .jog_i(jog_i), .pid_i(pid_i), .stage_switch_i(stage_switch_i),
        .stage_neg_i(stage_neg_i), .stage_time_i(stage_time_i), .shaft_pulse_input_i(shaft),
        .traverse_term_i(trav_t), .len_clear_term_i(clr_t), .dir_ext_i(dir_ext_i),
        .power_fail_i(power_fail_i), .freq_o(freq_o), .dir_o(dir_o), .stop_o(stop_o),
        .stage_skip_o(stage_skip_o), .traverse_active_o(trav_o), .nv_save_o(nv_save_o),
        .nv_len_o(nv_len_o));
    tlc_shaft_model tlc_shaft_model_inst (.clk_i(clk_i), .shaft_o(shaft));
    always #25 clk_i = ~clk_i;
    task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", w, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic bound(input int lim);
        if (n >= lim) begin
            errors++;
            stop_test();
        end
    endtask
    // one classic cycle; request held until ack is sampled high
    task automatic bus(input logic we, input logic [4:0] idx, input logic [15:0] wd);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {1'b0, idx, 2'b00};
        wb_dat_i <= {16'h0000, wd};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rdv = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        bound(20);
        @(posedge clk_i);
    endtask
    task automatic rdchk(input string w, input logic [4:0] i, input logic [31:0] e);
        bus(1'b0, i, 16'h0000);
        check(w, rdv, e);
    endtask
    task automatic wait_freq(input logic [15:0] f, input int lim);
        for (n = 0; n < lim && freq_o !== f; n++) @(posedge clk_i);
        bound(lim);
    endtask
    function automatic logic [15:0] exp_len(input int p, input int m, input int r);
        return 16'((longint'(p) * 10000 * m) / (longint'(r) * 10000));
    endfunction
    initial begin
        {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, run_i, run_rev_i, jog_i, pid_i} = '0;
        {stage_switch_i, stage_neg_i, trav_t, clr_t, dir_ext_i, power_fail_i} = '0;
        {wb_adr_i, wb_dat_i, errors, samples_checked} = '0;
        wb_sel_i = 4'h3;
        stage_time_i = 16'h0005;
        rst_i = 1'b1;
        seed = 78467;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (k = 0; k < CFG_NUM; k++) rdchk("reset value", 5'(k), {16'h0000, CFG_RST[k]});
        bus(1'b1, 5'h1F, 16'hA5A5);
        rdchk("unmapped", 5'h1F, 32'h0000_0000);
        $display("registers done");
        stage_time_i <= 16'h0000;
        repeat (4) @(posedge clk_i);
        check("stage skip", stage_skip_o, 1'b1);
        stage_time_i <= 16'h0005;
        repeat (4) @(posedge clk_i);
        check("stage kept", stage_skip_o, 1'b0);
        run_i <= 1'b1;
        for (k = 0; k < 8; k++) begin
            {stage_neg_i, run_rev_i, dir_ext_i} <= 3'(k);
            repeat (8) @(posedge clk_i);
            check("direction", dir_o, ^3'(k));
        end
        run_i <= 1'b0;
        $display("stage and direction done");
        bus(1'b1, IDX_CTRL, 16'h0020);
        bus(1'b1, IDX_CIRC, 16'h2710);
        bus(1'b1, IDX_PPR, 16'h0001);
        bus(1'b1, IDX_CENTRE, 16'h07D0);
        for (k = 0; k < 4; k++) begin
            mag = 16'(1000 * (1 + ($random(seed) & 3)));
            corr = ($random(seed) & 1) ? 16'h01F4 : 16'h03E8;
            bus(1'b1, IDX_MAG, mag);
            bus(1'b1, IDX_CORR, corr);
            bus(1'b1, IDX_ACTLEN, 16'h0000);
            n = 1 + ($random(seed) & 7);
            tlc_shaft_model_inst.burst(n);
            rdchk("length", IDX_ACTLEN, {16'h0000, exp_len(n, mag, corr)});
        end
        bus(1'b1, IDX_MAG, 16'h03E8);
        bus(1'b1, IDX_CORR, 16'h03E8);
        clr_t <= 1'b1;
        repeat (8) @(posedge clk_i);
        tlc_shaft_model_inst.burst(2);
        rdchk("length held clear", IDX_ACTLEN, 32'h0);
        clr_t <= 1'b0;
        repeat (8) @(posedge clk_i);
        tlc_shaft_model_inst.burst(1);
        rdchk("length after clear", IDX_ACTLEN, 32'h1);
        power_fail_i <= 1'b1;
        for (n = 0; n < 20 && nv_save_o !== 1'b1; n++) @(posedge clk_i);
        bound(20);
        check("saved length", nv_len_o, 16'h0001);
        power_fail_i <= 1'b0;
        run_i <= 1'b1;
        tlc_shaft_model_inst.burst(3);
        rdchk("length no target", IDX_ACTLEN, 32'h4);
        check("no stop at zero target", stop_o, 1'b0);
        bus(1'b1, IDX_SETLEN, 16'h0005);
        tlc_shaft_model_inst.burst(1);
        check("length stop", stop_o, 1'b1);
        run_i <= 1'b0;
        wait_freq(16'h0000, 4000);
        run_i <= 1'b1;
        repeat (200) @(posedge clk_i);
        check("start refused", freq_o, 16'h0000);
        run_i <= 1'b0;
        bus(1'b1, IDX_ACTLEN, 16'h0000);
        run_i <= 1'b1;
        repeat (200) @(posedge clk_i);
        check("start after clear", freq_o != 16'h0000, 1'b1);
        run_i <= 1'b0;
        wait_freq(16'h0000, 4000);
        $display("length done");
        bus(1'b1, IDX_WAIT, 16'h0002);
        bus(1'b1, IDX_JUMP, 16'h00C8);
        for (k = 0; k < 2; k++) begin
            up = k ? 16'h08FC : 16'h1388;
            bus(1'b1, IDX_FUPPER, up);
            // second pass: variable reference, same amplitude of 500
            bus(1'b1, IDX_CTRL, k ? 16'h000D : 16'h0009);
            bus(1'b1, IDX_AMP, k ? 16'h00FA : 16'h0064);
            run_i <= 1'b1;
            wait_freq(16'h03E8, 3000);
            check("preset hold", trav_o, 1'b0);
            for (n = 0; n < 3000 && trav_o !== 1'b1; n++) @(posedge clk_i);
            bound(3000);
            check("centre reached", freq_o, 16'h07D0);
            {fmax, fmin, jup, prev} = {16'h0000, 16'hFFFF, 16'h0000, freq_o};
            repeat (4500) begin
                @(posedge clk_i);
                fmax = (freq_o > fmax) ? freq_o : fmax;
                fmin = (freq_o < fmin) ? freq_o : fmin;
                jup = (freq_o > prev && freq_o - prev > jup) ? freq_o - prev : jup;
                prev = freq_o;
            end
            check("jump", jup, 16'h0064);
            check("top", fmax, k ? 16'h08FC : 16'h09C4);
            check("bottom", fmin, 16'h05DC);
            run_i <= 1'b0;
            wait_freq(16'h0000, 4000);
        end
        bus(1'b1, IDX_CTRL, 16'h000B);
        run_i <= 1'b1;
        for (n = 0; n < 3000 && trav_o !== 1'b1; n++) @(posedge clk_i);
        check("manual without terminal", trav_o, 1'b0);
        trav_t <= 1'b1;
        for (n = 0; n < 3000 && trav_o !== 1'b1; n++) @(posedge clk_i);
        bound(3000);
        jog_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        check("jog cancels", trav_o, 1'b0);
        {jog_i, run_i} <= 2'b00;
        wait_freq(16'h0000, 4000);
        bus(1'b1, IDX_CTRL, 16'h0005);
        run_i <= 1'b1;
        for (n = 0; n < 3000 && trav_o !== 1'b1; n++) @(posedge clk_i);
        bound(3000);
        stage_switch_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        check("stage switch", trav_o, 1'b0);
        stage_switch_i <= 1'b0;
        for (n = 0; n < 3000 && trav_o !== 1'b1; n++) @(posedge clk_i);
        bound(3000);
        repeat (200) @(posedge clk_i);
        run_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        up = freq_o;
        wait_freq(16'h0000, 4000);
        run_i <= 1'b1;
        for (n = 0; n < 3000 && trav_o !== 1'b1; n++) @(posedge clk_i);
        bound(3000);
        check("resume point", freq_o, up);
        run_i <= 1'b0;
        wait_freq(16'h0000, 4000);
        bus(1'b1, IDX_CTRL, 16'h0015);
        power_fail_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        power_fail_i <= 1'b0;
        bus(1'b1, IDX_CTRL, 16'h0005);
        run_i <= 1'b1;
        for (n = 0; n < 3000 && trav_o !== 1'b1; n++) @(posedge clk_i);
        bound(3000);
        check("memory dropped", freq_o, 16'h07D0);
        run_i <= 1'b0;
        $display("traverse done");
        stop_test();
    end
endmodule

// ### verilog/tlc_sync.sv
// three-stage pin synchroniser; output follows once stages two and three agree
`timescale 1ns/1ps
module tlc_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                s1_q[i] <= 1'b0;
                s2_q[i] <= 1'b0;
                s3_q[i] <= 1'b0;
                sync_o[i] <= 1'b0;
            end else begin
                s1_q[i] <= pin_i[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i]) begin
                    sync_o[i] <= s3_q[i];
                end
            end
        end
    end
endmodule

// ### verilog/tlc_top.sv
// traverse generator and fixed-length counter with a wishbone register file
`timescale 1ns/1ps
module tlc_top
    import tlc_pkg::*;
#(
    parameter int CYC_TENTH = CYC_PER_TENTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic run_i,
    input wire logic run_rev_i,
    input wire logic jog_i,
    input wire logic pid_i,
    input wire logic stage_switch_i,
    input wire logic stage_neg_i,
    input wire logic [15:0] stage_time_i,
    input wire logic shaft_pulse_input_i,
    input wire logic traverse_term_i,
    input wire logic len_clear_term_i,
    input wire logic dir_ext_i,
    input wire logic power_fail_i,
    output logic [15:0] freq_o,
    output logic dir_o,
    output logic stop_o,
    output logic stage_skip_o,
    output logic traverse_active_o,
    output logic nv_save_o,
    output logic [15:0] nv_len_o
);
    logic [PIN_NUM-1:0] pin_s;
    logic [15:0] cfg_q [CFG_NUM];
    logic [15:0] act_len_q;
    tlc_state_t state_q;
    logic [15:0] f_q;
    logic [39:0] acc_q;
    logic [31:0] tmr_q;
    logic resume_q;
    logic memo_v_q;
    logic memo_dir_q;
    logic [15:0] memo_f_q;
    logic shaft_q;
    logic pfail_q;
    logic [47:0] len_acc_q;

    tlc_sync #(.W(PIN_NUM)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i({power_fail_i, dir_ext_i, len_clear_term_i, traverse_term_i,
            shaft_pulse_input_i}),
        .sync_o(pin_s)
    );

    // ---------------- wishbone slave
    logic req;
    logic wr;
    logic [4:0] idx;
    logic [15:0] wmask;
    logic [15:0] wdat;
    logic [15:0] ctrl;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // writes commit at the edge where the master samples ack high
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i[7] == 1'b0;
    assign wdat = (cfg_q[idx] & ~wmask) | (wb_dat_i[15:0] & wmask);
    assign idx = wb_adr_i[6:2];
    assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign ctrl = cfg_q[IDX_CTRL];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < CFG_NUM; i++) begin
                cfg_q[i] <= CFG_RST[i];
            end
        end else if (wr && idx < 5'(CFG_NUM)) begin
            cfg_q[idx] <= wdat;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req) begin
            wb_dat_o <= 32'h0000_0000;
            if (wb_adr_i[7] == 1'b0 && idx < 5'(CFG_NUM)) begin
                wb_dat_o <= {16'h0000, cfg_q[idx]};
            end else if (wb_adr_i[7] == 1'b0 && idx == IDX_ACTLEN) begin
                wb_dat_o <= {16'h0000, act_len_q};
            end else if (wb_adr_i[7] == 1'b0 && idx == IDX_STATUS) begin
                wb_dat_o <= {f_q, 8'h00, stop_o, dir_o, memo_v_q, traverse_active_o,
                    1'b0, state_q};
            end
        end
    end

    // ---------------- length measurement
    logic len_reached;
    logic [47:0] len_thr;
    logic [47:0] len_sum;
    assign len_reached = ctrl[CTL_LEN_EN] && cfg_q[IDX_SETLEN] != 16'h0000
        && act_len_q >= cfg_q[IDX_SETLEN];
    // metres = pulses * circ(0.01cm) * mag / (ppr * corr * 10000)
    assign len_thr = 48'(cfg_q[IDX_PPR]) * 48'(cfg_q[IDX_CORR]) * 48'(M_PER_CM100);
    assign len_sum = len_acc_q + ((pin_s[PIN_SHAFT] && !shaft_q)
        ? 48'(cfg_q[IDX_CIRC]) * 48'(cfg_q[IDX_MAG]) : 48'h0);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shaft_q <= 1'b0;
            len_acc_q <= 48'h0;
            act_len_q <= ACTLEN_RST;
        end else begin
            shaft_q <= pin_s[PIN_SHAFT];
            if (pin_s[PIN_CLR]) begin
                len_acc_q <= 48'h0;
                act_len_q <= 16'h0000;
            end else if (wr && idx == IDX_ACTLEN) begin
                act_len_q <= (act_len_q & ~wmask) | (wb_dat_i[15:0] & wmask);
            end else if (ctrl[CTL_LEN_EN]) begin
                if (len_sum >= len_thr && len_thr != 48'h0) begin
                    len_acc_q <= len_sum - len_thr;
                    if (act_len_q != 16'hFFFF) begin
                        act_len_q <= act_len_q + 16'h0001;
                    end
                end else begin
                    len_acc_q <= len_sum;
                end
            end
        end
    end

    // ---------------- power-down save
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pfail_q <= 1'b0;
            nv_save_o <= 1'b0;
            nv_len_o <= 16'h0000;
        end else begin
            pfail_q <= pin_s[PIN_PFAIL];
            nv_save_o <= pin_s[PIN_PFAIL] && !pfail_q;
            if (pin_s[PIN_PFAIL] && !pfail_q) begin
                nv_len_o <= act_len_q;
            end
        end
    end

    // ---------------- traverse geometry
    logic run_ok;
    logic trav_on;
    logic [25:0] amp_p;
    logic [15:0] amp_w;
    logic [25:0] jmp_p;
    logic [15:0] jmp_w;
    logic [16:0] trav_up;
    logic [16:0] trav_lo;
    assign run_ok = run_i && !len_reached;
    assign trav_on = ctrl[CTL_TRAV_EN] && run_ok && !jog_i && !pid_i
        && (!ctrl[CTL_MANUAL] || pin_s[PIN_TRAV]);
    assign amp_p = (ctrl[CTL_VAR_AMP] ? cfg_q[IDX_CENTRE] : cfg_q[IDX_FMAX])
        * cfg_q[IDX_AMP][9:0];
    assign amp_w = 16'(amp_p / 26'(PERMILLE));
    assign jmp_p = amp_w * cfg_q[IDX_JUMP][9:0];
    assign jmp_w = 16'(jmp_p / 26'(PERMILLE));
    assign trav_up = {1'b0, cfg_q[IDX_CENTRE]} + {1'b0, amp_w};
    assign trav_lo = (cfg_q[IDX_CENTRE] > amp_w) ? {1'b0, cfg_q[IDX_CENTRE] - amp_w} : 17'h0;

    // ---------------- ramp engine: one frequency step whenever acc crosses thr
    logic [15:0] tgt;
    logic [16:0] inc;
    logic [15:0] tsel;
    logic [39:0] thr;
    logic [39:0] acc_sum;
    logic step;
    always_comb begin
        tgt = cfg_q[IDX_CENTRE];
        inc = {1'b0, cfg_q[IDX_FMAX]};
        tsel = (f_q > tgt) ? cfg_q[IDX_DEC] : cfg_q[IDX_ACC];
        unique case (state_q)
            ST_PRESET: begin
                tgt = cfg_q[IDX_PRESET];
                tsel = (f_q > tgt) ? cfg_q[IDX_DEC] : cfg_q[IDX_ACC];
            end
            ST_TRACK: begin
                tgt = resume_q ? memo_f_q : cfg_q[IDX_CENTRE];
                tsel = (f_q > tgt) ? cfg_q[IDX_DEC] : cfg_q[IDX_ACC];
            end
            ST_RISE: begin
                tgt = trav_up[16] ? 16'hFFFF : trav_up[15:0];
                inc = {amp_w, 1'b0};
                tsel = cfg_q[IDX_RISE];
            end
            ST_FALL: begin
                tgt = trav_lo[15:0];
                inc = {amp_w, 1'b0};
                tsel = cfg_q[IDX_FALL];
            end
            ST_STOP: begin
                tgt = 16'h0000;
                tsel = cfg_q[IDX_DEC];
            end
            ST_IDLE, ST_WAIT: begin
                tgt = f_q;
            end
        endcase
    end
    assign thr = 40'(tsel) * 40'(CYC_TENTH);
    assign acc_sum = acc_q + 40'(inc);
    assign step = (f_q != tgt) && (acc_sum >= thr);

    // ---------------- traverse state machine
    logic leave_trav;
    assign leave_trav = (state_q == ST_RISE || state_q == ST_FALL)
        && (!run_ok || !trav_on || stage_switch_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            f_q <= 16'h0000;
            acc_q <= 40'h0;
            tmr_q <= 32'h0;
            resume_q <= 1'b0;
        end else begin
            if (f_q == tgt) begin
                acc_q <= 40'h0;
            end else if (step) begin
                acc_q <= acc_sum - thr;
                f_q <= (f_q < tgt) ? f_q + 16'h0001 : f_q - 16'h0001;
            end else begin
                acc_q <= acc_sum;
            end
            if (!run_ok && state_q != ST_IDLE) begin
                state_q <= ST_STOP;
            end else begin
                unique case (state_q)
                    ST_IDLE: begin
                        if (run_ok) begin
                            if (trav_on && !ctrl[CTL_RESTART] && memo_v_q) begin
                                resume_q <= 1'b1;
                                state_q <= ST_TRACK;
                            end else if (trav_on && cfg_q[IDX_WAIT] != 16'h0000) begin
                                state_q <= ST_PRESET;
                            end else begin
                                state_q <= ST_TRACK;
                            end
                        end
                    end
                    ST_PRESET: begin
                        if (f_q == tgt) begin
                            tmr_q <= 32'(cfg_q[IDX_WAIT]) * 32'(CYC_TENTH);
                            state_q <= ST_WAIT;
                        end
                    end
                    ST_WAIT: begin
                        if (tmr_q <= 32'h1) begin
                            state_q <= ST_TRACK;
                        end else begin
                            tmr_q <= tmr_q - 32'h1;
                        end
                    end
                    ST_TRACK: begin
                        if (f_q == tgt && trav_on && !stage_switch_i) begin
                            state_q <= (resume_q && memo_dir_q) ? ST_FALL : ST_RISE;
                            resume_q <= 1'b0;
                        end
                    end
                    ST_RISE: begin
                        if (leave_trav) begin
                            state_q <= ST_TRACK;
                        end else if ({1'b0, f_q} >= trav_up) begin
                            f_q <= (f_q > jmp_w) ? f_q - jmp_w : 16'h0000;
                            acc_q <= 40'h0;
                            state_q <= ST_FALL;
                        end
                    end
                    ST_FALL: begin
                        if (leave_trav) begin
                            state_q <= ST_TRACK;
                        end else if ({1'b0, f_q} <= trav_lo) begin
                            f_q <= f_q + jmp_w;
                            acc_q <= 40'h0;
                            state_q <= ST_RISE;
                        end
                    end
                    ST_STOP: begin
                        resume_q <= 1'b0;
                        if (f_q == 16'h0000) begin
                            state_q <= ST_IDLE;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // remembered traverse point, kept across power loss only when stored and restart is off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            memo_v_q <= 1'b0;
            memo_dir_q <= 1'b0;
            memo_f_q <= 16'h0000;
        end else if (pin_s[PIN_PFAIL] && !pfail_q
            && (ctrl[CTL_NO_STORE] || ctrl[CTL_RESTART])) begin
            memo_v_q <= 1'b0;
        end else if (leave_trav && !run_ok) begin
            memo_v_q <= 1'b1;
            memo_dir_q <= (state_q == ST_FALL);
            memo_f_q <= f_q;
        end
    end

    // ---------------- outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            freq_o <= 16'h0000;
            dir_o <= 1'b0;
            stop_o <= 1'b0;
            stage_skip_o <= 1'b0;
            traverse_active_o <= 1'b0;
        end else begin
            if (f_q > cfg_q[IDX_FUPPER]) begin
                freq_o <= cfg_q[IDX_FUPPER];
            end else if (f_q < cfg_q[IDX_FLOWER] && state_q != ST_IDLE) begin
                freq_o <= cfg_q[IDX_FLOWER];
            end else begin
                freq_o <= f_q;
            end
            dir_o <= stage_neg_i ^ run_rev_i ^ pin_s[PIN_DIR];
            stop_o <= len_reached;
            stage_skip_o <= (stage_time_i == 16'h0000);
            traverse_active_o <= (state_q == ST_RISE || state_q == ST_FALL);
        end
    end

    // ---------------- checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence top_hit_s;
        state_q == ST_RISE && !leave_trav && run_ok && {1'b0, f_q} >= trav_up;
    endsequence
    sequence wait_hold_s;
        state_q == ST_WAIT && run_ok;
    endsequence

    stage_skip_a: assert property (stage_time_i == 16'h0000 |=> stage_skip_o)
        else $error("zero-time stage not flagged");
    dir_follow_a: assert property (##1 dir_o == $past(stage_neg_i ^ run_rev_i ^ pin_s[PIN_DIR]))
        else $error("direction does not follow sign and commands");
    jog_cancel_a: assert property ((jog_i || pid_i) && run_ok |=>
        !(state_q inside {ST_RISE, ST_FALL}))
        else $error("traverse not cancelled by jog or closed loop");
    jump_down_a: assert property (top_hit_s |=> state_q == ST_FALL
        && f_q == $past(f_q) - $past(jmp_w))
        else $error("wrong jump at traverse top");
    wait_hold_a: assert property (wait_hold_s |=> f_q == $past(f_q))
        else $error("frequency moved during preset wait");
    out_clamp_a: assert property (##1 freq_o <= $past(cfg_q[IDX_FUPPER]))
        else $error("output above upper limit");
    len_stop_a: assert property (len_reached |=> stop_o ##1 (state_q inside {ST_STOP, ST_IDLE}))
        else $error("no stop at length reached");
    no_start_a: assert property (state_q == ST_IDLE && len_reached |=> state_q == ST_IDLE)
        else $error("started with length reached");
    len_clear_a: assert property (pin_s[PIN_CLR] [*2] |-> act_len_q == 16'h0000)
        else $error("length not held clear");
    zero_set_a: assert property (cfg_q[IDX_SETLEN] == 16'h0000 |=> !stop_o)
        else $error("stop with zero set length");
endmodule
